// *** design/crypto_dma_consts.svh ***
// Offsets, field positions and reset values of the crypto DMA status block.
// Assumes a 32-bit APB register bus with byte addresses.
// How it works
// - Chain base address register: 32 bits, read/write, resets to zero.
// - Setting both DMA enable and fetch enable starts descriptor fetch at the chain base address.
// - Status bits 31-29 report fault mode: normal, preboot, key-encryption-key, content-key.
// - Status bits 28-26 report faulting operation: 001 encrypt, 010 decrypt, 100 authenticate.
// - Status bits 25-24 report faulting access: descriptor, association, source, destination.
// - Status bits 21-18 show descriptor processor state, codes 0000 to 0110.
// - Status bit 17 reads one once a DMA start has occurred.
// - Status bit 16 reads one while the descriptor processor is active.
// - Status bits 15-0 mirror the current descriptor control word.
// - Access error flag sets when an outside memory access answers with error.
// - Packet done flag sets when a DMA packet completes.
// - Last descriptor flag sets when the last descriptor has been processed.
// - Pending flag is the OR of all interrupt sources.
// - Unimplemented status and flag bits read as zero.
// - Interrupt asserts only with global enable and an enabled pending source.
// - Polling on an invalid descriptor waits the programmed count, then refetches.
// - DMA runs only while the DMA enable bit is set.
// - Current descriptor address is readable.
`ifndef CRYPTO_DMA_CONSTS_SVH
`define CRYPTO_DMA_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CHAIN_BASE 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_FLAGS 8'h08
`define OFS_CONTROL 8'h0c
`define OFS_INT_ENABLE 8'h10
`define OFS_REFETCH_WAIT 8'h14
`define OFS_CUR_DESC 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_DMA_ENABLE 0
`define CTL_POLL_ENABLE 1
`define CTL_FETCH_ENABLE 2
`define IEN_GLOBAL 0
`define IEN_LAST 1
`define IEN_PACKET 2
`define IEN_ACCESS 3
`define DSC_VALID 31
`define DSC_LAST 30
`define DSC_HAS_SA 29
`define DSC_SA_OFS 32'h0000_0004
`define DSC_NEXT_OFS 32'h0000_0008

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_WORD 32'h0000_0000

`endif

// *** design/crypto_dma_pkg.sv ***
// Types shared by the crypto DMA status block.
// Assumes nothing of its surroundings.
package crypto_dma_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_SA, ST_DATA, ST_DONE, ST_WAIT} proc_state_e;

    typedef logic [3:0] state_code_t;
    typedef logic [1:0] phase_code_t;

endpackage : crypto_dma_pkg

// *** design/refetch_wait_timer.sv ***
// Down-counter that pulses once the programmed wait has elapsed.
// Assumes a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module refetch_wait_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    // Result
    output logic expired
);
    initial
    begin
        if (WIDTH < 1)
            $error("refetch_wait_timer: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] count_r, count_nxt;
    logic run_r, run_nxt;
    logic expired_r, expired_nxt;

    always_comb
    begin
        count_nxt = count_r;
        run_nxt = run_r;
        expired_nxt = 1'b0;
        if (load)
        begin
            count_nxt = loadValue;
            run_nxt = 1'b1;
        end
        else if (run_r)
        begin
            if (count_r == '0)
            begin
                run_nxt = 1'b0;
                expired_nxt = 1'b1;
            end
            else
                count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_r <= '0;
            run_r <= 1'b0;
            expired_r <= 1'b0;
        end
        else if (ce)
        begin
            count_r <= count_nxt;
            run_r <= run_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign expired = expired_r;
endmodule : refetch_wait_timer

// *** design/crypto_dma_status.sv ***
// Descriptor processor, status and interrupt source registers of the crypto DMA.
// Assumes an APB master and a word-read memory port that answers with ack and err.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "crypto_dma_consts.svh"
module crypto_dma_status
    import crypto_dma_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int WAIT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Descriptor memory port
    output logic memReq,
    output logic [31:0] memAddr,
    input wire logic memAck,
    input wire logic memErr,
    input wire logic [31:0] memRdata,
    // Cipher datapath handshake
    output logic dataStart,
    input wire logic dataDone,
    input wire logic dataErr,
    input wire logic dataErrDest,
    // Interrupt
    output logic irq
);
    initial
    begin
        if (ADDR_W < 5 || WAIT_W < 1 || WAIT_W > 32)
            $error("crypto_dma_status: unsupported parameter values");
    end

    // ----------------------------------------
    // APB access decode
    // ----------------------------------------
    logic setup, wrDone, rdDone, pready_r, pready_nxt;
    logic [7:0] ofs;
    assign setup = psel && !penable;
    assign wrDone = psel && penable && pready_r && pwrite;
    assign rdDone = psel && penable && pready_r && !pwrite;
    assign ofs = 8'(paddr);

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [31:0] chainBase_r, chainBase_nxt;
    logic [2:0] control_r, control_nxt;
    logic [3:0] intEnable_r, intEnable_nxt;
    logic [WAIT_W-1:0] refetchWait_r, refetchWait_nxt;
    logic dmaOn, pollOn, fetchOn;
    assign dmaOn = control_r[`CTL_DMA_ENABLE];
    assign pollOn = control_r[`CTL_POLL_ENABLE];
    assign fetchOn = control_r[`CTL_FETCH_ENABLE];

    always_comb
    begin
        chainBase_nxt = chainBase_r;
        control_nxt = control_r;
        intEnable_nxt = intEnable_r;
        refetchWait_nxt = refetchWait_r;
        if (wrDone)
        begin
            case (ofs)
                `OFS_CHAIN_BASE: chainBase_nxt = pwdata;
                `OFS_CONTROL: control_nxt = pwdata[2:0];
                `OFS_INT_ENABLE: intEnable_nxt = pwdata[3:0];
                `OFS_REFETCH_WAIT: refetchWait_nxt = pwdata[WAIT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            chainBase_r <= `RST_WORD;
            control_r <= '0;
            intEnable_r <= '0;
            refetchWait_r <= '0;
        end
        else if (ce)
        begin
            chainBase_r <= chainBase_nxt;
            control_r <= control_nxt;
            intEnable_r <= intEnable_nxt;
            refetchWait_r <= refetchWait_nxt;
        end
    end

    // ----------------------------------------
    // Descriptor processor
    // ----------------------------------------
    proc_state_e state_r, state_nxt;
    logic [31:0] curDesc_r, curDesc_nxt;
    logic [31:0] nextDesc_r, nextDesc_nxt;
    logic [31:0] ctrlWord_r, ctrlWord_nxt;
    logic [31:0] memAddr_r, memAddr_nxt;
    logic memReq_r, memReq_nxt;
    logic dataStart_r, dataStart_nxt;
    logic started_r, started_nxt;
    logic accessFlag_r, accessFlag_nxt;
    logic packetFlag_r, packetFlag_nxt;
    logic lastFlag_r, lastFlag_nxt;
    logic [2:0] faultMode_r, faultMode_nxt;
    logic [2:0] faultOp_r, faultOp_nxt;
    phase_code_t faultPhase_r, faultPhase_nxt;
    logic waitLoad, waitExpired, memFault, clearFlags, anyFault, startCond;
    phase_code_t phaseNow;

    // Timer sits in its own module so the wait can be reused by other engines
    refetch_wait_timer #(
        .WIDTH(WAIT_W)
    ) u_wait (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .load(waitLoad),
        .loadValue(refetchWait_r),
        .expired(waitExpired)
    );

    assign memFault = memReq_r && memAck && memErr;
    assign anyFault = memFault || (state_r == ST_DATA && dataErr);
    assign clearFlags = rdDone && ofs == `OFS_INT_FLAGS;
    assign startCond = dmaOn && fetchOn && !started_r;

    always_comb
    begin
        case (state_r)
            ST_SA: phaseNow = 2'b01;
            ST_DATA: phaseNow = dataErrDest ? 2'b11 : 2'b10;
            default: phaseNow = 2'b00;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        curDesc_nxt = curDesc_r;
        nextDesc_nxt = nextDesc_r;
        ctrlWord_nxt = ctrlWord_r;
        memAddr_nxt = memAddr_r;
        memReq_nxt = memReq_r;
        dataStart_nxt = 1'b0;
        started_nxt = started_r;
        waitLoad = 1'b0;
        faultMode_nxt = faultMode_r;
        faultOp_nxt = faultOp_r;
        faultPhase_nxt = faultPhase_r;
        // Flag set wins over clear-on-read in the same cycle
        accessFlag_nxt = (accessFlag_r && !clearFlags) || anyFault;
        packetFlag_nxt = (packetFlag_r && !clearFlags) || (state_r == ST_DONE);
        lastFlag_nxt = (lastFlag_r && !clearFlags) || (state_r == ST_DONE && ctrlWord_r[`DSC_LAST]);
        if (!dmaOn)
        begin
            // Dropping the enable abandons the chain at once
            state_nxt = ST_IDLE;
            memReq_nxt = 1'b0;
            started_nxt = 1'b0;
        end
        else if (anyFault)
        begin
            // Mode and operation come from the descriptor; unknown values fold to legal codes
            faultMode_nxt = {1'b0, ctrlWord_r[5:4]};
            case (ctrlWord_r[2:0])
                3'h2: faultOp_nxt = 3'h2;
                3'h4: faultOp_nxt = 3'h4;
                default: faultOp_nxt = 3'h1;
            endcase
            faultPhase_nxt = phaseNow;
            state_nxt = ST_IDLE;
            memReq_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (startCond)
                    begin
                        started_nxt = 1'b1;
                        curDesc_nxt = chainBase_r;
                        memAddr_nxt = chainBase_r;
                        memReq_nxt = 1'b1;
                        state_nxt = ST_FETCH;
                    end
                ST_FETCH:
                    if (memAck)
                    begin
                        memReq_nxt = 1'b0;
                        ctrlWord_nxt = memRdata;
                        if (memRdata[`DSC_VALID])
                        begin
                            memAddr_nxt = curDesc_r + `DSC_NEXT_OFS;
                            memReq_nxt = 1'b1;
                            state_nxt = ST_LOAD;
                        end
                        else if (pollOn)
                        begin
                            waitLoad = 1'b1;
                            state_nxt = ST_WAIT;
                        end
                        else
                            state_nxt = ST_IDLE;
                    end
                ST_WAIT:
                    if (waitExpired)
                    begin
                        memAddr_nxt = curDesc_r;
                        memReq_nxt = 1'b1;
                        state_nxt = ST_FETCH;
                    end
                ST_LOAD:
                    if (memAck)
                    begin
                        nextDesc_nxt = memRdata;
                        if (ctrlWord_r[`DSC_HAS_SA])
                        begin
                            memAddr_nxt = curDesc_r + `DSC_SA_OFS;
                            state_nxt = ST_SA;
                        end
                        else
                        begin
                            memReq_nxt = 1'b0;
                            dataStart_nxt = 1'b1;
                            state_nxt = ST_DATA;
                        end
                    end
                ST_SA:
                    if (memAck)
                    begin
                        memReq_nxt = 1'b0;
                        dataStart_nxt = 1'b1;
                        state_nxt = ST_DATA;
                    end
                ST_DATA:
                    if (dataDone)
                        state_nxt = ST_DONE;
                ST_DONE:
                    if (ctrlWord_r[`DSC_LAST])
                        state_nxt = ST_IDLE;
                    else
                    begin
                        curDesc_nxt = nextDesc_r;
                        memAddr_nxt = nextDesc_r;
                        memReq_nxt = 1'b1;
                        state_nxt = ST_FETCH;
                    end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            curDesc_r <= `RST_WORD;
            nextDesc_r <= `RST_WORD;
            ctrlWord_r <= `RST_WORD;
            memAddr_r <= `RST_WORD;
            memReq_r <= 1'b0;
            dataStart_r <= 1'b0;
            started_r <= 1'b0;
            accessFlag_r <= 1'b0;
            packetFlag_r <= 1'b0;
            lastFlag_r <= 1'b0;
            faultMode_r <= '0;
            faultOp_r <= 3'h1;
            faultPhase_r <= '0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            curDesc_r <= curDesc_nxt;
            nextDesc_r <= nextDesc_nxt;
            ctrlWord_r <= ctrlWord_nxt;
            memAddr_r <= memAddr_nxt;
            memReq_r <= memReq_nxt;
            dataStart_r <= dataStart_nxt;
            started_r <= started_nxt;
            accessFlag_r <= accessFlag_nxt;
            packetFlag_r <= packetFlag_nxt;
            lastFlag_r <= lastFlag_nxt;
            faultMode_r <= faultMode_nxt;
            faultOp_r <= faultOp_nxt;
            faultPhase_r <= faultPhase_nxt;
        end
    end

    // ----------------------------------------
    // Status view and interrupt
    // ----------------------------------------
    state_code_t stateCode;
    logic active, pending;
    logic [31:0] statusWord, flagWord, rdWord;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt, irq_r, irq_nxt;

    always_comb
    begin
        case (state_r)
            ST_FETCH: stateCode = 4'h1;
            ST_LOAD: stateCode = 4'h2;
            ST_DATA: stateCode = 4'h3;
            ST_DONE: stateCode = 4'h4;
            ST_WAIT: stateCode = 4'h5;
            ST_SA: stateCode = 4'h6;
            default: stateCode = 4'h0;
        endcase
    end

    assign active = state_r != ST_IDLE;
    assign pending = accessFlag_r || packetFlag_r || lastFlag_r;
    // Bits 23-22 and 31-4 are tied low
    assign statusWord = {faultMode_r, faultOp_r, faultPhase_r, 2'b00, stateCode, started_r, active,
                         ctrlWord_r[15:0]};
    assign flagWord = {28'h0, accessFlag_r, packetFlag_r, lastFlag_r, pending};

    always_comb
    begin
        case (ofs)
            `OFS_CHAIN_BASE: rdWord = chainBase_r;
            `OFS_STATUS: rdWord = statusWord;
            `OFS_INT_FLAGS: rdWord = flagWord;
            `OFS_CONTROL: rdWord = {29'h0, control_r};
            `OFS_INT_ENABLE: rdWord = {28'h0, intEnable_r};
            `OFS_REFETCH_WAIT: rdWord = 32'(refetchWait_r);
            `OFS_CUR_DESC: rdWord = curDesc_r;
            default: rdWord = 32'h0;
        endcase
    end

    always_comb
    begin
        pready_nxt = setup;
        prdata_nxt = setup ? rdWord : prdata_r;
        pslverr_nxt = setup && (ofs > `OFS_CUR_DESC || ofs[1:0] != 2'b00 ||
                      (pwrite && (ofs == `OFS_STATUS || ofs == `OFS_INT_FLAGS || ofs == `OFS_CUR_DESC)));
        irq_nxt = intEnable_r[`IEN_GLOBAL] && ((accessFlag_r && intEnable_r[`IEN_ACCESS]) ||
                  (packetFlag_r && intEnable_r[`IEN_PACKET]) || (lastFlag_r && intEnable_r[`IEN_LAST]));
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign memReq = memReq_r;
    assign memAddr = memAddr_r;
    assign dataStart = dataStart_r;
    assign irq = irq_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_base_write;
        @(posedge sys_clk) disable iff (rst) ce && wrDone && ofs == `OFS_CHAIN_BASE |=> chainBase_r == $past(pwdata);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base write lost");

    property p_start_addr;
        @(posedge sys_clk) disable iff (rst) ce && state_r == ST_IDLE && startCond && !anyFault
            |=> memReq_r && memAddr_r == $past(chainBase_r) && started_r;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("fetch not at base");

    property p_mode_legal;
        @(posedge sys_clk) disable iff (rst) faultMode_r[2] == 1'b0;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("reserved mode code");

    property p_op_legal;
        @(posedge sys_clk) disable iff (rst) faultOp_r == 3'h1 || faultOp_r == 3'h2 || faultOp_r == 3'h4;
    endproperty
    a_op_legal: assert property (p_op_legal) else $error("reserved operation code");

    property p_sa_phase;
        @(posedge sys_clk) disable iff (rst) ce && dmaOn && state_r == ST_SA && memFault |=> faultPhase_r == 2'b01;
    endproperty
    a_sa_phase: assert property (p_sa_phase) else $error("wrong fault phase");

    property p_read_status;
        @(posedge sys_clk) disable iff (rst) ce && setup && !pwrite && ofs == `OFS_STATUS
            |=> prdata_r[16] == $past(active) && prdata_r[23:22] == 2'b00 && prdata_r[21:18] <= 4'h6;
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_access_flag;
        @(posedge sys_clk) disable iff (rst) ce && memFault |=> accessFlag_r ##1 1'b1;
    endproperty
    a_access_flag: assert property (p_access_flag) else $error("access error not flagged");

    property p_irq_gate;
        @(posedge sys_clk) disable iff (rst) irq_r |-> $past(intEnable_r[`IEN_GLOBAL]) && $past(pending);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_dma_off;
        @(posedge sys_clk) disable iff (rst) ce && !dmaOn |=> state_r == ST_IDLE && !memReq_r;
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("runs while disabled");

    property p_fault_hold;
        @(posedge sys_clk) disable iff (rst) !(ce && dmaOn && anyFault) |=> $stable(faultMode_r) && $stable(faultPhase_r);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault fields changed");

    c_sa_chain: cover property (@(posedge sys_clk) disable iff (rst) state_r == ST_SA ##[1:50] state_r == ST_DONE);
    c_poll: cover property (@(posedge sys_clk) disable iff (rst) state_r == ST_WAIT ##[1:200] state_r == ST_LOAD);
    c_fault: cover property (@(posedge sys_clk) disable iff (rst) memFault ##1 accessFlag_r);
    c_irq: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq_r));
endmodule : crypto_dma_status

// *** tb/sys_mem_model.sv ***
// Behavioural system memory and datapath stand-in for the crypto DMA.
// Assumes word reads on memReq, answered after two cycles of wait.
`timescale 1ns/1ps
module sys_mem_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Memory port
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    output logic memAck,
    output logic memErr,
    output logic [31:0] memRdata,
    // Datapath and error injection
    input wire logic dataStart,
    output logic dataDone,
    input wire logic [31:0] errAddr
);
    logic [31:0] mem [0:63];
    logic [1:0] waitCnt;
    logic [2:0] doneDly;
    assign dataDone = doneDly[2];
    always @(posedge sys_clk)
    begin
        memAck <= 1'b0;
        memErr <= 1'b0;
        // Released data toggles every cycle so a stale word does not hold its value
        memRdata <= ~memRdata;
        doneDly <= {doneDly[1:0], dataStart};
        if (rst)
        begin
            waitCnt <= 2'h0;
            doneDly <= 3'h0;
            memRdata <= 32'h0000_0000;
        end
        else if (memReq && !memAck)
        begin
            waitCnt <= waitCnt + 2'h1;
            if (waitCnt == 2'h2)
            begin
                memAck <= 1'b1;
                memErr <= (memAddr == errAddr);
                memRdata <= mem[memAddr[7:2]];
                waitCnt <= 2'h0;
            end
        end
    end
endmodule : sys_mem_model

// *** tb/testbench.sv ***
// Self-checking bench for the crypto DMA status block.
// Assumes the memory model answers every request; APB answers in its first access cycle.
`timescale 1ns/1ps
`include "crypto_dma_consts.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] errAddr = 32'hffff_fffc;
    logic [31:0] prdata, memAddr, memRdata, rd;
    logic pready, pslverr, memReq, memAck, memErr, dataStart, dataDone, irq, er;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;
    int t0;
    always #2.5 sys_clk = ~sys_clk;
    crypto_dma_status u_crypto_dma_status (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memErr(memErr), .memRdata(memRdata), .dataStart(dataStart), .dataDone(dataDone),
        .dataErr(1'b0), .dataErrDest(1'b0), .irq(irq));
    sys_mem_model u_sys_mem_model (.sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memAddr(memAddr),
        .memAck(memAck), .memErr(memErr), .memRdata(memRdata), .dataStart(dataStart),
        .dataDone(dataDone), .errAddr(errAddr));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        // Sample pready and the answer at the rising edge that ends the access
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) n_errors++;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_irq;
        k = 0;
        while (irq !== 1'b1 && k < 500) begin @(negedge sys_clk); k++; end
        chk("irq raised", 32'h1, {31'h0, irq});
    endtask : wait_irq
    task automatic stop_test;
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs;
        apb(1'b0, `OFS_CHAIN_BASE, 32'h0); chk("base reset", 32'h0, rd);
        apb(1'b0, `OFS_STATUS, 32'h0); chk("status reset", 32'h0400_0000, rd);
        apb(1'b0, `OFS_INT_FLAGS, 32'h0); chk("flags reset", 32'h0, rd);
        apb(1'b1, `OFS_CHAIN_BASE, 32'ha5c3_0f40);
        apb(1'b0, `OFS_CHAIN_BASE, 32'h0); chk("base rw", 32'ha5c3_0f40, rd);
        apb(1'b1, `OFS_STATUS, 32'hffff_ffff); chk("ro write err", 32'h1, {31'h0, er});
        apb(1'b0, `OFS_STATUS, 32'h0); chk("status kept", 32'h0400_0000, rd);
        apb(1'b0, 8'h1c, 32'h0); chk("unmapped err", 32'h1, {31'h0, er});
    endtask : test_regs
    task automatic test_disabled;
        apb(1'b1, `OFS_CONTROL, 32'h4);
        repeat (10) @(negedge sys_clk);
        chk("no fetch", 32'h0, {31'h0, memReq});
        apb(1'b1, `OFS_CONTROL, 32'h0);
    endtask : test_disabled
    task automatic test_chain;
        u_sys_mem_model.mem[16] = 32'hc000_0012;
        u_sys_mem_model.mem[18] = 32'h0000_0000;
        apb(1'b1, `OFS_CHAIN_BASE, 32'h40);
        apb(1'b1, `OFS_INT_ENABLE, 32'hf);
        apb(1'b1, `OFS_CONTROL, 32'h5);
        k = 0;
        while (memReq !== 1'b1 && k < 100) begin @(negedge sys_clk); k++; end
        chk("first fetch", 32'h40, memAddr);
        apb(1'b0, `OFS_STATUS, 32'h0); chk("run flags", 32'h3, {30'h0, rd[17:16]});
        wait_irq();
        apb(1'b0, `OFS_STATUS, 32'h0); chk("idle status", 32'h0402_0012, rd);
        apb(1'b0, `OFS_INT_FLAGS, 32'h0); chk("done flags", 32'h7, rd);
        apb(1'b0, `OFS_INT_FLAGS, 32'h0); chk("flags clear", 32'h0, rd);
        chk("irq clear", 32'h0, {31'h0, irq});
    endtask : test_chain
    task automatic test_fault;
        u_sys_mem_model.mem[32] = 32'h8000_0024;
        apb(1'b1, `OFS_CONTROL, 32'h0);
        errAddr <= 32'h88;
        apb(1'b1, `OFS_CHAIN_BASE, 32'h80);
        apb(1'b1, `OFS_CONTROL, 32'h5);
        wait_irq();
        apb(1'b0, `OFS_INT_FLAGS, 32'h0); chk("error flags", 32'h9, rd);
        apb(1'b0, `OFS_STATUS, 32'h0); chk("fault fields", 32'h50, {24'h0, rd[31:24]});
        chk("fault state", 32'h0, {26'h0, rd[23:18]});
        apb(1'b0, `OFS_STATUS, 32'h0); chk("fault held", 32'h50, {24'h0, rd[31:24]});
        apb(1'b0, `OFS_CUR_DESC, 32'h0); chk("cur desc", 32'h80, rd);
    endtask : test_fault
    task automatic test_poll_sa;
        u_sys_mem_model.mem[48] = 32'h2000_0011;
        apb(1'b1, `OFS_CONTROL, 32'h0);
        apb(1'b1, `OFS_REFETCH_WAIT, 32'h14);
        apb(1'b1, `OFS_CHAIN_BASE, 32'hc0);
        errAddr <= 32'hc4;
        apb(1'b1, `OFS_CONTROL, 32'h7);
        k = 0;
        while (memReq !== 1'b1 && k < 100) begin @(negedge sys_clk); k++; end
        while (memReq !== 1'b0 && k < 100) begin @(negedge sys_clk); k++; end
        t0 = cyc;
        apb(1'b0, `OFS_STATUS, 32'h0); chk("wait state", 32'h5, {28'h0, rd[21:18]});
        u_sys_mem_model.mem[48] = 32'he000_0011;
        while (memReq !== 1'b1 && k < 100) begin @(negedge sys_clk); k++; end
        chk("refetch addr", 32'hc0, memAddr);
        chk("refetch wait", 32'h1, {31'h0, cyc - t0 >= 20 && cyc - t0 <= 24});
        wait_irq();
        apb(1'b0, `OFS_INT_FLAGS, 32'h0); chk("sa error flags", 32'h9, rd);
        apb(1'b0, `OFS_STATUS, 32'h0); chk("sa fault fields", 32'h25, {24'h0, rd[31:24]});
        chk("sa ctrl word", 32'h11, {16'h0, rd[15:0]});
    endtask : test_poll_sa
    // ----------------------------------------
    // Sequence and timeout
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_regs();
        test_disabled();
        test_chain();
        test_fault();
        test_poll_sa();
        stop_test();
    end
endmodule : testbench
